// ===== design/tsc_channel.sv
// three-wire clocked serial channel: register port, shifter, clock control
// assumes prescale_tick and stop_mode come from logic on clk; pins are async
`default_nettype none

module tsc_channel import tsc_pkg::*; #(
  parameter bit IS_FIRST = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // shared prescaler and power state
  input wire logic prescale_tick,
  input wire logic stop_mode,
  // serial lines
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  output logic so_out,
  input wire logic si_in,
  // interrupt
  output logic irq
);

  tsc_chan_s r_reg;
  tsc_chan_s r_next;
  logic half_pulse;
  logic run;
  logic edge_ev;
  logic lead;
  logic start_ev;
  logic load_ev;
  logic frame_end;
  logic ovr_ev;
  logic snz_ok;
  logic drive;
  logic tx_bit;
  logic rx_bit;
  logic [4:0] edges_n;
  logic [4:0] frame_edges;
  logic [7:0] rsh_n;

  // ************************************************
  // clock divider
  // ************************************************
  assign run = r_reg.ctl.en && r_reg.ctl.master && r_reg.st == S_XFER;

  tsc_sck_div #(
    .GAP_MIN(IS_FIRST ? GAP_FIRST : GAP_OTHER)
  ) u_div (
    .clk(clk),
    .rst_b(rst_b),
    .run(run),
    .prescale_tick(prescale_tick),
    .div(r_reg.div),
    .half_pulse(half_pulse)
  );

  // ************************************************
  // next state
  // ************************************************
  always_comb begin
    r_next = r_reg;
    start_ev = 1'b0;
    load_ev = 1'b0;
    frame_end = 1'b0;
    ovr_ev = 1'b0;
    edges_n = r_reg.edges + 5'h01;
    rsh_n = r_reg.rsh;
    // pins pass two flops before any use
    r_next.si_s1 = si_in;
    r_next.si_s2 = r_reg.si_s1;
    r_next.sck_s1 = sck_in;
    r_next.sck_s2 = r_reg.sck_s1;
    r_next.sck_s3 = r_reg.sck_s2;
    frame_edges = r_reg.ctl.len8 ? EDGES_8 : EDGES_7;
    snz_ok = !stop_mode || (IS_FIRST && r_reg.ctl.snz);
    // slave edges seen three cycles late, hence the far-side rate cap
    edge_ev = r_reg.ctl.master ? half_pulse : (r_reg.sck_s2 != r_reg.sck_s3);
    lead = !r_reg.edges[0];
    rx_bit = r_reg.si_s2 ^ r_reg.ctl.inv;

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        ADDR_CTRL: r_next.ctl = tsc_ctrl_s'(reg_wdata[CTL_W-1:0]);
        ADDR_DIV: r_next.div = reg_wdata[7:0];
        ADDR_TXDATA: begin
          // a write to a full buffer is dropped
          if (!r_reg.txfull) begin
            r_next.txbuf = reg_wdata[7:0];
            r_next.txfull = 1'b1;
          end
        end
        ADDR_IRQMASK: r_next.mask = reg_wdata[STAT_W-1:0];
        ADDR_CLEAR: begin
          if (reg_wdata[CLR_OVR]) begin
            r_next.ovr = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // register reads, data one cycle later
    r_next.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL: r_next.rdata = {{(32-CTL_W){1'b0}}, r_reg.ctl};
        ADDR_DIV: r_next.rdata = {24'h00_0000, r_reg.div};
        ADDR_TXDATA: r_next.rdata = {24'h00_0000, r_reg.txbuf};
        ADDR_RXDATA: begin
          r_next.rdata = {24'h00_0000, r_reg.rxbuf};
          r_next.rxfull = 1'b0;
        end
        ADDR_IRQSTAT: begin
          r_next.rdata = {{(32-STAT_W){1'b0}}, r_reg.stat};
          r_next.stat = '0;
        end
        ADDR_IRQMASK: r_next.rdata = {{(32-STAT_W){1'b0}}, r_reg.mask};
        ADDR_STATE: begin
          r_next.rdata = {{(32-STATE_W){1'b0}}, r_reg.ovr, r_reg.rxfull, r_reg.txfull, r_reg.st == S_XFER};
        end
        default: ;
      endcase
    end

    // transfer control
    if (!r_reg.ctl.en) begin
      r_next.st = S_IDLE;
      r_next.edges = '0;
      r_next.sck_o = r_reg.ctl.cpol;
    end else begin
      unique case (r_reg.st)
        S_IDLE, S_READY: begin
          r_next.sck_o = r_reg.ctl.cpol;
          if (r_reg.st == S_IDLE && r_reg.txfull) begin
            load_ev = 1'b1;
            r_next.tsh = r_reg.txbuf;
            r_next.txfull = 1'b0;
            r_next.st = r_reg.ctl.master ? S_XFER : S_READY;
          end else if (!r_reg.ctl.master && snz_ok && edge_ev && r_reg.sck_s2 != r_reg.ctl.cpol) begin
            // receive-only frame when nothing waits to be sent
            start_ev = 1'b1;
            r_next.st = S_XFER;
            if (r_reg.st == S_IDLE) begin
              r_next.tsh = TX_DUMMY;
            end
          end
        end
        S_XFER: ;
      endcase
    end

    // one edge of the serial clock
    if (r_reg.ctl.en && (r_reg.st == S_XFER || start_ev) && edge_ev) begin
      if (r_reg.ctl.master) begin
        r_next.sck_o = !r_reg.sck_o;
      end
      if (lead != r_reg.ctl.cpha) begin
        // sample edge
        if (r_reg.ctl.msb) begin
          rsh_n = {r_reg.rsh[6:0], rx_bit};
        end else if (r_reg.ctl.len8) begin
          rsh_n = {rx_bit, r_reg.rsh[7:1]};
        end else begin
          rsh_n = {1'b0, rx_bit, r_reg.rsh[6:1]};
        end
        r_next.rsh = rsh_n;
      end else if (!(r_reg.ctl.cpha && r_reg.edges == 5'h00)) begin
        // change edge; the first leading edge of late phase only starts drive
        r_next.tsh = r_reg.ctl.msb ? {r_reg.tsh[6:0], 1'b0} : {1'b0, r_reg.tsh[7:1]};
      end
      if (edges_n == frame_edges) begin
        frame_end = 1'b1;
        r_next.st = S_IDLE;
        r_next.edges = '0;
        r_next.rxbuf = r_reg.ctl.len8 ? rsh_n : {1'b0, rsh_n[6:0]};
        // unread word still held after any read this cycle
        if (r_next.rxfull) begin
          ovr_ev = 1'b1;
          r_next.ovr = 1'b1;
        end
        r_next.rxfull = 1'b1;
      end else begin
        r_next.edges = edges_n;
      end
    end

    // events set after reads so a set wins over a clear
    if (r_reg.ctl.bemode ? load_ev : frame_end) begin
      r_next.stat[IRQ_DONE] = 1'b1;
    end
    if (ovr_ev) begin
      r_next.stat[IRQ_OVR] = 1'b1;
    end
    if (frame_end && stop_mode) begin
      r_next.stat[IRQ_WAKE] = 1'b1;
    end

    // data out, early phase drives as soon as the word is loaded
    if (r_next.st == S_XFER) begin
      drive = !r_reg.ctl.cpha || r_next.edges != 5'h00;
    end else begin
      drive = r_next.st == S_READY && !r_reg.ctl.cpha;
    end
    if (r_reg.ctl.msb) begin
      tx_bit = r_reg.ctl.len8 ? r_next.tsh[7] : r_next.tsh[6];
    end else begin
      tx_bit = r_next.tsh[0];
    end
    r_next.so_o = drive ? (tx_bit ^ r_reg.ctl.inv) : SO_IDLE;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r_reg <= '0;
      r_reg.div <= DIV_RST;
      r_reg.mask <= MASK_RST;
      r_reg.so_o <= SO_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  assign reg_rdata = r_reg.rdata;
  assign sck_out = r_reg.sck_o;
  assign sck_oe = r_reg.ctl.en && r_reg.ctl.master;
  assign so_out = r_reg.so_o;
  assign irq = |(r_reg.stat & r_reg.mask);

  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_end_unread;
    frame_end && r_reg.rxfull && !(reg_rd && reg_addr == ADDR_RXDATA);
  endsequence

  sequence s_master_rest;
    r_reg.ctl.en && r_reg.ctl.master && r_reg.st != S_XFER ##1 r_reg.st != S_XFER && $stable(r_reg.ctl);
  endsequence

  a_sck_idle_level: assert property (s_master_rest |-> sck_out == r_reg.ctl.cpol)
    else $error("clock not at idle level");
  a_slave_no_drive: assert property (!r_reg.ctl.master |-> !sck_oe)
    else $error("slave drives the clock");
  a_frame_edges: assert property ($fell(r_reg.st == S_XFER) && r_reg.ctl.en |->
    $past(edge_ev) && $past(r_reg.edges) == $past(frame_edges) - 5'h01)
    else $error("frame ended at wrong edge count");
  a_sck_paced: assert property (r_reg.ctl.master && r_reg.ctl.en && $past(r_reg.ctl.en) &&
    $past(r_reg.st == S_XFER) && $changed(sck_out) |-> $past(half_pulse))
    else $error("clock moved without divider");
  a_sck_rate: assert property (!IS_FIRST && r_reg.st == S_XFER && $changed(sck_out) |=> $stable(sck_out))
    else $error("clock faster than a quarter");
  a_ovr_set: assert property (s_end_unread |=> r_reg.ovr && r_reg.stat[IRQ_OVR])
    else $error("overrun not flagged");
  a_ovr_hold: assert property (r_reg.ovr && !(reg_wr && reg_addr == ADDR_CLEAR && reg_wdata[CLR_OVR])
    |=> r_reg.ovr)
    else $error("overrun dropped without clear");
  a_done_irq: assert property ((r_reg.ctl.bemode ? load_ev : frame_end)
    |=> r_reg.stat[IRQ_DONE] && (irq || !r_reg.mask[IRQ_DONE]))
    else $error("done event lost");
  a_low_power_receive_state_gate: assert property ($rose(r_reg.st == S_XFER) && !r_reg.ctl.master
    |-> !$past(stop_mode) || (IS_FIRST && $past(r_reg.ctl.snz)))
    else $error("reception started in stop");

endmodule : tsc_channel

`default_nettype wire

// ===== design/tsc_pkg.sv
// constants, types and register map of the three-wire serial channel
// assumes one system clock domain; prescaler tick comes from logic on that clock
`default_nettype none

package tsc_pkg;

  // ************************************************
  // register map (byte addresses)
  // ************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_DIV = 8'h04;
  localparam logic [7:0] ADDR_TXDATA = 8'h08;
  localparam logic [7:0] ADDR_RXDATA = 8'h0c;
  localparam logic [7:0] ADDR_IRQSTAT = 8'h10;
  localparam logic [7:0] ADDR_IRQMASK = 8'h14;
  localparam logic [7:0] ADDR_STATE = 8'h18;
  localparam logic [7:0] ADDR_CLEAR = 8'h1c;

  // ************************************************
  // field positions and widths
  // ************************************************
  localparam int CTL_W = 9;
  localparam int STAT_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_OVR = 1;
  localparam int IRQ_WAKE = 2;
  localparam int CLR_OVR = 0;
  localparam int STATE_W = 4;

  // ************************************************
  // reset values
  // ************************************************
  localparam logic [7:0] DIV_RST = 8'h03;
  localparam logic [STAT_W-1:0] MASK_RST = 3'h0;
  localparam logic SO_IDLE = 1'b1;
  localparam logic [7:0] TX_DUMMY = 8'hff;

  // ************************************************
  // frame and rate counts
  // ************************************************
  localparam logic [4:0] EDGES_8 = 5'h10;
  localparam logic [4:0] EDGES_7 = 5'h0e;
  localparam int SYS_PER_SCK_FIRST = 2;
  localparam int SYS_PER_SCK_OTHER = 4;
  localparam logic [1:0] GAP_FIRST = 2'(SYS_PER_SCK_FIRST / 2 - 1);
  localparam logic [1:0] GAP_OTHER = 2'(SYS_PER_SCK_OTHER / 2 - 1);
  localparam logic [1:0] GAP_SAT = 2'h3;

  // ************************************************
  // types
  // ************************************************
  typedef enum logic [1:0] {
    S_IDLE,
    S_READY,
    S_XFER
  } tsc_state_e;

  // bit 0 is en
  typedef struct packed {
    logic snz;
    logic bemode;
    logic inv;
    logic cpol;
    logic cpha;
    logic msb;
    logic len8;
    logic master;
    logic en;
  } tsc_ctrl_s;

  typedef struct packed {
    tsc_state_e st;
    tsc_ctrl_s ctl;
    logic [7:0] div;
    logic [STAT_W-1:0] mask;
    logic [STAT_W-1:0] stat;
    logic [7:0] txbuf;
    logic txfull;
    logic [7:0] tsh;
    logic [7:0] rsh;
    logic [7:0] rxbuf;
    logic rxfull;
    logic ovr;
    logic [4:0] edges;
    logic sck_o;
    logic so_o;
    logic si_s1;
    logic si_s2;
    logic sck_s1;
    logic sck_s2;
    logic sck_s3;
    logic [31:0] rdata;
  } tsc_chan_s;

  typedef struct packed {
    logic [7:0] cnt;
    logic [1:0] gap;
  } tsc_div_s;

endpackage : tsc_pkg

`default_nettype wire

// ===== design/tsc_sck_div.sv
// per-channel serial clock divider, counts shared prescaler ticks
// assumes prescale_tick is a one-cycle pulse on clk
`default_nettype none

module tsc_sck_div import tsc_pkg::*; #(
  parameter logic [1:0] GAP_MIN = GAP_OTHER
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic run,
  input wire logic prescale_tick,
  input wire logic [7:0] div,
  // half period elapsed
  output logic half_pulse
);

  tsc_div_s r_reg;
  tsc_div_s r_next;

  // ************************************************
  // divider
  // ************************************************
  always_comb begin
    r_next = r_reg;
    half_pulse = 1'b0;
    if (!run) begin
      r_next = '0;
    end else begin
      if (r_reg.gap != GAP_SAT) begin
        r_next.gap = r_reg.gap + 2'h1;
      end
      // gap floor caps the rate even with a fast prescaler
      if (r_reg.cnt >= div && r_reg.gap >= GAP_MIN) begin
        half_pulse = 1'b1;
        r_next.cnt = '0;
        r_next.gap = '0;
      end else if (prescale_tick && r_reg.cnt < div) begin
        r_next.cnt = r_reg.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_pulse_space: assert property (half_pulse ##1 half_pulse |-> GAP_MIN == 2'h0)
    else $error("divider pulses too close");
  a_idle_quiet: assert property (!run |-> !half_pulse)
    else $error("divider pulse while stopped");

endmodule : tsc_sck_div

`default_nettype wire

// ===== tb/tsc_slave_model.sv
// far-side serial device for master-mode tests: shifts a word out, collects what arrives
// assumes sck is registered on clk, so a one-cycle edge detect sees every toggle
`default_nettype none

module tsc_slave_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // mode, mirrors the channel setup
  input wire logic cpol,
  input wire logic cpha,
  input wire logic msb,
  input wire logic len8,
  input wire logic restart,
  input wire logic [7:0] word,
  // serial lines
  input wire logic sck,
  input wire logic so,
  output logic si,
  output logic [7:0] got
);
  timeunit 1ns;
  timeprecision 1ps;

  logic sck_d;
  logic so_d;
  logic last;
  logic [3:0] lead_n;
  logic [3:0] trail_n;
  logic [3:0] n;

  function automatic logic [2:0] pos(input logic [3:0] k);
    return 3'(msb ? n - 4'h1 - k : k);
  endfunction : pos

  assign n = len8 ? 4'h8 : 4'h7;
  // late phase: line is undefined until the first leading edge, so it toggles
  assign si = (!cpha || lead_n != 4'h0) ? word[pos(cpha ? lead_n - 4'h1 : trail_n)] : ~last;

  // ************************************************
  // follow the master clock
  // ************************************************
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_d <= 1'b0;
      so_d <= 1'b1;
      last <= 1'b1;
      lead_n <= 4'h0;
      trail_n <= 4'h0;
      got <= 8'h00;
    end else begin
      sck_d <= sck;
      // take the bit that stood at the clock edge; the last bit may drop on that same edge
      so_d <= so;
      last <= si;
      if (sck != sck_d && sck != cpol) begin
        lead_n <= lead_n + 4'h1;
        if (!cpha) begin
          got[pos(lead_n)] <= so_d;
        end
      end
      if (sck != sck_d && sck == cpol) begin
        if (cpha) begin
          got[pos(trail_n)] <= so_d;
        end
        trail_n <= (trail_n + 4'h1 == n) ? 4'h0 : trail_n + 4'h1;
        if (trail_n + 4'h1 == n) begin
          lead_n <= 4'h0;
        end
      end
      // mode changes move the clock line; forget those toggles
      if (restart) begin
        lead_n <= 4'h0;
        trail_n <= 4'h0;
      end
    end
  end
endmodule : tsc_slave_model

`default_nettype wire

// ===== tb/tb_top.sv
// self-checking bench for the first serial channel with a far-side model
// assumes random prescaler ticks; the bench clocks the slave frames itself
`default_nettype none

module tb_top import tsc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic prescale_tick = 1'b0;
  logic stop_mode = 1'b0;
  logic sck_in = 1'b0;
  logic tb_si = 1'b1;
  logic slv = 1'b0;
  logic restart = 1'b0;
  logic [31:0] seed = 32'h9d43_1408;
  logic [31:0] tk = 32'h9d43_1408;
  logic [31:0] reg_rdata;
  logic [31:0] rd_v;
  logic sck_out, sck_oe, so_out, m_si, irq, cpol, cpha, msb, len8, inv;
  logic [7:0] mword = 8'h00;
  logic [7:0] got, w, m;
  int errors = 0;
  int samples_checked = 0;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  always #5 clk = ~clk;

  // irregular ticks so the divider is not only seen at one rate
  always @(posedge clk) begin
    tk <= lfsr(tk);
    prescale_tick <= tk[0] | tk[1];
  end

  tsc_channel #(.IS_FIRST(1'b1)) u_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .prescale_tick(prescale_tick),
    .stop_mode(stop_mode), .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe), .so_out(so_out),
    .si_in(slv ? tb_si : m_si), .irq(irq));

  tsc_slave_model u_far (.clk(clk), .rst_b(rst_b), .cpol(cpol), .cpha(cpha), .msb(msb), .len8(len8),
    .restart(restart), .word(mword), .sck(sck_out), .so(so_out), .si(m_si), .got(got));

  // ************************************************
  // bus and check tasks
  // ************************************************
  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // extra edge at the end keeps two strobes from being set in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    rd_v = reg_rdata;
    @(posedge clk);
  endtask : rd

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(what, rd_v, exp);
  endtask : rchk

  task automatic wait_clear(input logic [31:0] bits);
    for (int i = 0; i < 3000; i++) begin
      rd(ADDR_STATE);
      if ((rd_v & bits) === 32'h0) begin
        return;
      end
    end
    chk("state wait", rd_v & bits, 32'h0);
    test_done();
  endtask : wait_clear

  task automatic fresh();
    repeat (2) @(posedge clk);
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
  endtask : fresh

  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rchk("ctrl", ADDR_CTRL, 32'h0000_0000);
    rchk("div", ADDR_DIV, {24'h0, DIV_RST});
    rchk("mask", ADDR_IRQMASK, {29'h0, MASK_RST});
    rchk("unmapped", 8'h20, 32'h0000_0000);
    chk("so idle", {sck_oe, so_out}, {1'b0, SO_IDLE});
    $display("test reset done");
    // every clock sense, phase, order and length, random data and polarity
    wr(ADDR_IRQMASK, 32'h0000_0001);
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      {cpol, cpha, msb, len8} <= 4'(i);
      inv = seed[4];
      mword <= seed[15:8];
      w = seed[23:16];
      m = i[0] ? 8'hff : 8'h7f;
      wr(ADDR_DIV, 32'(4'h4 + seed[1:0]));
      wr(ADDR_CTRL, {23'h0, 2'b00, inv, 4'(i), 2'b11});
      fresh();
      @(negedge clk);
      chk("sck idle", {sck_oe, sck_out}, {1'b1, cpol});
      @(posedge clk);
      wr(ADDR_TXDATA, {24'h0, w});
      wait_clear(32'h0000_0003);
      chk("far got", got & m, (inv ? ~w : w) & m);
      @(negedge clk);
      chk("irq done", irq, 1'b1);
      @(posedge clk);
      rchk("stat done", ADDR_IRQSTAT, 32'h0000_0001);
      @(negedge clk);
      chk("irq low", irq, 1'b0);
      @(posedge clk);
      rchk("rx data", ADDR_RXDATA, {24'h0, (inv ? ~mword : mword) & m});
    end
    $display("test master done");
    // back to back words, buffer-empty events, first word unread
    seed = lfsr(seed);
    {cpol, cpha, msb, len8} <= 4'h3;
    wr(ADDR_IRQMASK, 32'h0000_0002);
    wr(ADDR_CTRL, 32'h0000_008f);
    fresh();
    wr(ADDR_TXDATA, {24'h0, seed[7:0]});
    wait_clear(32'h0000_0002);
    wr(ADDR_TXDATA, {24'h0, seed[15:8]});
    wait_clear(32'h0000_0003);
    chk("far got 2", got, seed[15:8]);
    rchk("state ovr", ADDR_STATE, 32'h0000_000c);
    @(negedge clk);
    chk("irq ovr", irq, 1'b1);
    @(posedge clk);
    rchk("stat ovr", ADDR_IRQSTAT, 32'h0000_0003);
    rchk("state held", ADDR_STATE, 32'h0000_000c);
    wr(ADDR_CLEAR, 32'h0000_0001);
    rchk("state clr", ADDR_STATE, 32'h0000_0004);
    rchk("rx last", ADDR_RXDATA, {24'h0, mword});
    rchk("tx back", ADDR_TXDATA, {24'h0, seed[15:8]});
    $display("test overrun done");
    // slave frame during stop state, refused without the low_power_receive_state bit
    for (int k = 0; k < 2; k++) begin
      seed = lfsr(seed);
      w = seed[7:0];
      wr(ADDR_IRQMASK, 32'h0000_0004);
      wr(ADDR_CTRL, {23'h0, k[0], 8'h0d});
      // a waiting word parks the slave ready, first bit already on the line
      if (k == 1) begin
        wr(ADDR_TXDATA, {24'h0, ~w});
      end
      slv <= 1'b1;
      stop_mode <= 1'b1;
      for (int b = 7; b >= 0; b--) begin
        tb_si <= w[b];
        repeat (4) @(posedge clk);
        if (k == 1) begin
          chk("slave so", so_out, {31'h0, ~w[b]});
        end
        sck_in <= 1'b1;
        repeat (4) @(posedge clk);
        sck_in <= 1'b0;
      end
      repeat (8) @(posedge clk);
      tb_si <= ~w[0];
      stop_mode <= 1'b0;
      @(posedge clk);
      rchk("low_power_receive_state state", ADDR_STATE, {28'h0, 1'b0, k[0], 2'b00});
      rchk("wake stat", ADDR_IRQSTAT, k[0] ? 32'h0000_0005 : 32'h0000_0000);
      if (k == 1) begin
        rchk("low_power_receive_state rx", ADDR_RXDATA, {24'h0, w});
      end
    end
    $display("test low_power_receive_state done");
    test_done();
  end
endmodule : tb_top

`default_nettype wire
